// [logic/icf_top.sv]
// interrupt control and flag registers with an AHB-Lite slave port
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module icf_top
(
   input  wire  logic              hclk,
   input  wire  logic              hresetn,
   input  wire  logic              hsel,
   input  wire  logic [31:0]       haddr,
   input  wire  logic [1:0]        htrans,
   input  wire  logic              hwrite,
   input  wire  logic [2:0]        hsize,
   input  wire  logic [31:0]       hwdata,
   input  wire  logic              hready,
   output var   logic [31:0]       hrdata,
   output       logic              hreadyout,
   output       logic              hresp,
   input  wire  logic              timer0_overflow,
   input  wire  logic [3:0]        ext_pin,
   input  wire  logic [7:0]        per_pin_change_flags,
   input  wire  icf_pkg::icf_periph_s periph_event,
   input  wire  logic [7:0]        periph_enable,
   input  wire  logic [7:0]        periph_priority,
   input  wire  logic              irq_accept,
   input  wire  logic              irq_accept_high,
   input  wire  logic              irq_return,
   input  wire  logic              irq_return_high,
   output var   icf_pkg::icf_req_s irq_req,
   output var   logic              portb_pullup_disable
);
   import icf_pkg::*;

   logic [7:0] main_reg;
   logic [7:0] edges_reg;
   logic [7:0] pins_reg;
   logic [7:0] pflags_reg;
   logic       priority_mode_select;
   logic [3:0] pin_prev;
   logic       ph_write;
   logic [7:0] ph_addr;
   logic [7:0] wbyte;
   logic [3:0] pin_edge;
   logic       port_change_flag;
   logic [7:0] main_view;
   logic [7:0] pflags_view;
   logic       global_high_enable;
   logic       peripheral_low_enable;
   logic [4:0] core_pend;
   logic [7:0] per_pend;
   logic       any_core;
   logic       any_per;
   logic       next_req_high;
   logic       next_req_low;
   logic       addr_take;
   logic       wr_main;
   logic       wr_edges;
   logic       wr_pins;
   logic       wr_pflags;
   logic       wr_mode;

   // one selected edge on a pin, sampled against last cycle's level
   function automatic logic edge_hit(input logic now, input logic prev,
                                     input logic rising);
      edge_hit = rising ? (now & ~prev) : (~now & prev);
   endfunction : edge_hit

   // flag update: written value, then any set event ORed on top
   function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                            input logic [7:0] wval,
                                            input logic [7:0] wmask,
                                            input logic [7:0] setv);
      flag_next = ((cur & ~wmask) | (wval & wmask)) | setv;
   endfunction : flag_next

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_take = hsel & hready & htrans[1];
   assign wbyte     = hwdata[7:0];

   // data phase bookkeeping; zero wait states so one cycle each
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end
      else
      begin
         ph_write <= addr_take & hwrite & (haddr[31:8] == 24'h000000);
         ph_addr  <= haddr[7:0];
      end
   end

   assign wr_main   = ph_write & (ph_addr == ADDR_MAIN);
   assign wr_edges  = ph_write & (ph_addr == ADDR_EDGES);
   assign wr_pins   = ph_write & (ph_addr == ADDR_PINS);
   assign wr_pflags = ph_write & (ph_addr == ADDR_PFLAGS);
   assign wr_mode   = ph_write & (ph_addr == ADDR_MODE);

   // edge detection for the four external pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_prev <= 4'h0;
      else
         pin_prev <= ext_pin;
   end

   always_comb
   begin
      // pin 0 selected by the highest edge bit, pin 3 by the lowest
      for (int i = 0; i < 4; i++)
         pin_edge[i] = edge_hit(ext_pin[i], pin_prev[i],
                                edges_reg[EDG_SEL0 - i]);
   end

   assign port_change_flag = |per_pin_change_flags;

   // main register: enables plus timer0 and pin 0 flags
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         main_reg <= RST_MAIN;
      else
      begin
         main_reg <= flag_next(main_reg, wbyte, {8{wr_main}},
                               {5'h00, timer0_overflow,
                                pin_edge[0], 1'b0});
         // core accept/return act on the global enables; they beat a write
         if (irq_accept)
         begin
            if (!priority_mode_select || irq_accept_high)
               main_reg[MAIN_GHE] <= 1'b0;
            else
               main_reg[MAIN_PLE] <= 1'b0;
         end
         else if (irq_return)
         begin
            if (!priority_mode_select || irq_return_high)
               main_reg[MAIN_GHE] <= 1'b1;
            else
               main_reg[MAIN_PLE] <= 1'b1;
         end
         // bit 0 is never stored; it mirrors the per-pin flags
         main_reg[MAIN_PCF] <= 1'b0;
      end
   end

   // edges and priorities register: plain storage
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         edges_reg <= RST_EDGES;
      else if (wr_edges)
         edges_reg <= wbyte;
   end

   // external pins register: priorities, enables, pin 1..3 flags
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pins_reg <= RST_PINS;
      else
         pins_reg <= flag_next(pins_reg, wbyte, {8{wr_pins}},
                               {5'h00, pin_edge[3:1]});
   end

   // peripheral flags: receive and transmit bits are live levels
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pflags_reg <= RST_PFLAGS;
      else
         pflags_reg <= flag_next(pflags_reg, wbyte,
                                 {8{wr_pflags}} & ~PF_RO_MASK,
                                 periph_event & ~PF_RO_MASK);
   end

   // mode selector; clear after reset gives compatibility mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         priority_mode_select <= 1'b0;
      else if (wr_mode)
         priority_mode_select <= wbyte[MODE_SEL];
   end

   always_comb
   begin
      main_view            = main_reg;
      main_view[MAIN_PCF]  = port_change_flag;
      pflags_view          = pflags_reg;
      pflags_view[PF_RX]   = periph_event.rx_full;
      pflags_view[PF_TX]   = periph_event.tx_empty;
   end

   assign global_high_enable    = main_reg[MAIN_GHE];
   assign peripheral_low_enable = main_reg[MAIN_PLE];
   assign portb_pullup_disable  = edges_reg[EDG_PUD];

   // pending = flag and own enable; flags never look at enables
   always_comb
   begin
      core_pend[0] = main_reg[MAIN_T0F] & main_reg[MAIN_T0E];
      core_pend[1] = main_reg[MAIN_P0F] & main_reg[MAIN_P0E];
      core_pend[2] = port_change_flag & main_reg[MAIN_PCE];
      core_pend[3] = pins_reg[PIN_FL1] & pins_reg[PIN_EN1];
      core_pend[4] = pins_reg[PIN_FL1 + 1] & pins_reg[PIN_EN1 + 1] |
                     pins_reg[PIN_FL1 + 2] & pins_reg[PIN_EN1 + 2];
   end

   assign per_pend = pflags_view & periph_enable;
   assign any_core = |core_pend;
   assign any_per  = |per_pend;

   // per-source priority; pin 0 has no bit and is always high
   logic       hi_core;
   logic       lo_core;
   logic       hi_per;
   logic       lo_per;

   always_comb
   begin
      hi_core = (main_reg[MAIN_T0F] & main_reg[MAIN_T0E] & edges_reg[EDG_T0P]) |
                core_pend[1] |
                (core_pend[2] & edges_reg[EDG_PCP]) |
                (pins_reg[PIN_FL1] & pins_reg[PIN_EN1] & pins_reg[PIN_P1P]) |
                (pins_reg[1] & pins_reg[4] & pins_reg[PIN_P2P]) |
                (pins_reg[2] & pins_reg[5] & edges_reg[EDG_P3P]);
      lo_core = (main_reg[MAIN_T0F] & main_reg[MAIN_T0E] & ~edges_reg[EDG_T0P]) |
                (core_pend[2] & ~edges_reg[EDG_PCP]) |
                (pins_reg[PIN_FL1] & pins_reg[PIN_EN1] & ~pins_reg[PIN_P1P]) |
                (pins_reg[1] & pins_reg[4] & ~pins_reg[PIN_P2P]) |
                (pins_reg[2] & pins_reg[5] & ~edges_reg[EDG_P3P]);
      hi_per  = |(per_pend & periph_priority);
      lo_per  = |(per_pend & ~periph_priority);
   end

   always_comb
   begin
      if (!priority_mode_select)
      begin
         // priority bits ignored; everything goes to the high line
         next_req_high = global_high_enable &
                         (any_core | (peripheral_low_enable & any_per));
         next_req_low  = 1'b0;
      end
      else
      begin
         next_req_high = global_high_enable & (hi_core | hi_per);
         next_req_low  = global_high_enable & peripheral_low_enable &
                         (lo_core | lo_per);
      end
   end

   // requests registered so the core sees clean levels
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_req <= '{req_high: 1'b0, req_low: 1'b0, vector: VEC_HIGH};
      else
      begin
         irq_req.req_high <= next_req_high;
         irq_req.req_low  <= next_req_low;
         // high wins the vector when both are asking
         if (next_req_low && !next_req_high)
            irq_req.vector <= VEC_LOW;
         else
            irq_req.vector <= VEC_HIGH;
      end
   end

   // read data captured in the address phase; unmapped reads as zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (addr_take && !hwrite)
      begin
         if (haddr[31:8] != 24'h000000)
            hrdata <= 32'h00000000;
         else
         begin
            case (haddr[7:0])
               ADDR_MAIN:   hrdata <= {24'h000000, main_view};
               ADDR_EDGES:  hrdata <= {24'h000000, edges_reg};
               ADDR_PINS:   hrdata <= {24'h000000, pins_reg};
               ADDR_PFLAGS: hrdata <= {24'h000000, pflags_view};
               ADDR_MODE:   hrdata <= {31'h00000000, priority_mode_select};
               ADDR_STATUS: hrdata <= {14'h0000, irq_req.req_high,
                                       irq_req.req_low, irq_req.vector};
               default:     hrdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule : icf_top
`default_nettype wire

// [logic/icf_pkg.sv]
// package for the interrupt control and flag register block
package icf_pkg;

   localparam logic [7:0] ADDR_MAIN     = 8'h00;
   localparam logic [7:0] ADDR_EDGES    = 8'h04;
   localparam logic [7:0] ADDR_PINS     = 8'h08;
   localparam logic [7:0] ADDR_PFLAGS   = 8'h0C;
   localparam logic [7:0] ADDR_MODE     = 8'h10;
   localparam logic [7:0] ADDR_STATUS   = 8'h14;

   localparam logic [7:0] RST_MAIN      = 8'h00;
   localparam logic [7:0] RST_EDGES     = 8'hFF;
   localparam logic [7:0] RST_PINS      = 8'hC0;
   localparam logic [7:0] RST_PFLAGS    = 8'h00;

   // main register fields
   localparam int MAIN_GHE   = 7;
   localparam int MAIN_PLE   = 6;
   localparam int MAIN_T0E   = 5;
   localparam int MAIN_P0E   = 4;
   localparam int MAIN_PCE   = 3;
   localparam int MAIN_T0F   = 2;
   localparam int MAIN_P0F   = 1;
   localparam int MAIN_PCF   = 0;
   // edges / priorities register fields
   localparam int EDG_PUD    = 7;
   localparam int EDG_SEL0   = 6;
   localparam int EDG_T0P    = 2;
   localparam int EDG_P3P    = 1;
   localparam int EDG_PCP    = 0;
   // external pins register fields
   localparam int PIN_P2P    = 7;
   localparam int PIN_P1P    = 6;
   localparam int PIN_EN1    = 3;
   localparam int PIN_FL1    = 0;
   // peripheral flags: read-only positions
   localparam int PF_RX      = 5;
   localparam int PF_TX      = 4;
   localparam logic [7:0] PF_RO_MASK = 8'h30;
   // mode register field
   localparam int MODE_SEL   = 0;

   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW  = 16'h0018;

   localparam logic [1:0] TRANS_NONSEQ = 2'b10;
   localparam logic [2:0] SIZE_WORD    = 3'b010;

   // peripheral events, bit order matches the peripheral flag register
   typedef struct packed {
      logic par_slave;
      logic conv_done;
      logic rx_full;
      logic tx_empty;
      logic sync_done;
      logic t1_gate;
      logic t2_match;
      logic t1_ovf;
   } icf_periph_s;

   typedef struct packed {
      logic        req_high;
      logic        req_low;
      logic [15:0] vector;
   } icf_req_s;

endpackage : icf_pkg

// [dv/icf_top_asserts.sv]
// port assertions for the interrupt control block
`timescale 1ns/10ps
`default_nettype none
module icf_top_asserts
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              irq_accept,
   input wire logic              irq_accept_high,
   input wire logic              irq_return,
   input wire icf_pkg::icf_req_s irq_req,
   input wire logic              portb_pullup_disable
);
   import icf_pkg::*;
   logic rd_c;
   logic wr_c;
   logic wr_edges_c;
   logic wr_main_c;
   assign rd_c = hsel && hready && htrans[1] && !hwrite;
   assign wr_c = hsel && hready && htrans[1] && hwrite;
   assign wr_edges_c = wr_c && haddr == {24'h0, ADDR_EDGES};
   assign wr_main_c = wr_c && haddr == {24'h0, ADDR_MAIN};
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_vec_high;
      irq_req.req_high |-> irq_req.vector == VEC_HIGH;
   endproperty
   a_vec_high: assert property (p_vec_high)
      else $error("high request without high vector");
   property p_vec_low;
      irq_req.req_low && !irq_req.req_high |-> irq_req.vector == VEC_LOW;
   endproperty
   a_vec_low: assert property (p_vec_low)
      else $error("low request without low vector");
   // return in the data phase would override the write, so it is excluded
   property p_gate_off;
      wr_main_c ##1 (!hwdata[MAIN_GHE] && !irq_return)
         |-> ##2 !(irq_req.req_high || irq_req.req_low);
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("request survives cleared global enable");
   property p_accept;
      irq_accept && irq_accept_high ##1 !irq_return
         |=> !irq_req.req_high && !irq_req.req_low;
   endproperty
   a_accept: assert property (p_accept)
      else $error("request survives accept");
   property p_pud;
      $changed(portb_pullup_disable) |-> $past(wr_edges_c, 2) || $past(wr_edges_c, 3);
   endproperty
   a_pud: assert property (p_pud)
      else $error("pull-up disable moved without a write");
   property p_unmapped;
      rd_c && haddr[31:8] != 24'h0 |=> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_hold;
      !rd_c |=> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved without a read");
   property p_upper;
      hrdata[31:18] == 14'h0;
   endproperty
   a_upper: assert property (p_upper)
      else $error("unused read bits set");
endmodule : icf_top_asserts
bind icf_top icf_top_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .irq_accept(irq_accept), .irq_accept_high(irq_accept_high),
   .irq_return(irq_return), .irq_req(irq_req), .portb_pullup_disable(portb_pullup_disable));
`default_nettype wire

// [dv/icf_partner.sv]
// model of the core and of the interrupt sources
`timescale 1ns/10ps
`default_nettype none
module icf_partner
(
   input  wire logic                 hclk,
   output var  logic                 timer0_overflow,
   output var  logic [3:0]           ext_pin,
   output var  logic [7:0]           per_pin_change_flags,
   output var  icf_pkg::icf_periph_s periph_event,
   output var  logic [7:0]           periph_enable,
   output var  logic [7:0]           periph_priority,
   output var  logic                 irq_accept,
   output var  logic                 irq_accept_high,
   output var  logic                 irq_return,
   output var  logic                 irq_return_high
);
   import icf_pkg::*;
   initial
   begin
      {timer0_overflow, ext_pin, per_pin_change_flags, periph_event} = '0;
      {periph_enable, periph_priority} = '0;
      {irq_accept, irq_accept_high, irq_return, irq_return_high} = '0;
   end
   // levels hold until the next call; one call high then low is a pulse
   task automatic src(input logic t0, input logic [3:0] pin, input logic [7:0] pcf,
                      input logic [7:0] pev);
      @(posedge hclk);
      timer0_overflow <= t0;
      ext_pin <= pin;
      per_pin_change_flags <= pcf;
      periph_event <= pev;
   endtask : src
   task automatic per(input logic [7:0] en, input logic [7:0] pri);
      @(posedge hclk);
      periph_enable <= en;
      periph_priority <= pri;
   endtask : per
   // core strobes last exactly one cycle, as an instruction would
   task automatic core(input logic acc, input logic ret, input logic high);
      @(posedge hclk);
      irq_accept <= acc;
      irq_return <= ret;
      irq_accept_high <= high;
      irq_return_high <= high;
      @(posedge hclk);
      irq_accept <= 1'b0;
      irq_return <= 1'b0;
   endtask : core
endmodule : icf_partner
`default_nettype wire

// [dv/irq_control_and_flag_regs_tb_top.sv]
// self-checking bench for the interrupt control block
`timescale 1ns/10ps
`default_nettype none
module irq_control_and_flag_regs_tb_top;
   import icf_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, portb_pullup_disable;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic        timer0_overflow, irq_accept, irq_accept_high, irq_return, irq_return_high;
   logic [3:0]  ext_pin;
   logic [7:0]  per_pin_change_flags, periph_enable, periph_priority;
   icf_periph_s periph_event;
   icf_req_s    irq_req;
   int          fails, checks_done;
   icf_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer0_overflow, .ext_pin,
      .per_pin_change_flags, .periph_event, .periph_enable, .periph_priority, .irq_accept,
      .irq_accept_high, .irq_return, .irq_return_high, .irq_req, .portb_pullup_disable);
   icf_partner partner_u (.hclk, .timer0_overflow, .ext_pin, .per_pin_change_flags,
      .periph_event, .periph_enable, .periph_priority, .irq_accept, .irq_accept_high,
      .irq_return, .irq_return_high);
   always #10 hclk = ~hclk;
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // vector only matters while a request stands
   task automatic rq(input logic h, input logic l, input logic [15:0] v);
      checks_done++;
      if ({irq_req.req_high, irq_req.req_low, (h | l) ? irq_req.vector : v} !== {h, l, v})
      begin
         fails++;
         $display("MISMATCH t=%0t request %h", $time, irq_req);
      end
   endtask : rq
   task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= TRANS_NONSEQ;
      hsize <= SIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 8'h00);
      chk(r, e);
   endtask : rd
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic ev(input logic t0, input logic [3:0] p, input logic [7:0] c, input logic [7:0] e);
      partner_u.src(t0, p, c, e);
      partner_u.src(1'b0, p, 8'h00, 8'h00);
   endtask : ev
   initial
   begin
      repeat (5000) @(posedge hclk);
      fails++;
      close_out();
   end
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      fails = 0;
      checks_done = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ADDR_MAIN, RST_MAIN);
      rd(ADDR_EDGES, RST_EDGES);
      rd(ADDR_PINS, RST_PINS);
      rd(ADDR_PFLAGS, RST_PFLAGS);
      rd(32'h100, 32'h0);
      chk({31'h0, portb_pullup_disable}, 32'h1);
      chk({30'h0, hreadyout, hresp}, 32'h2);
      wr(ADDR_EDGES, 8'h00);
      rd(ADDR_EDGES, 8'h00);
      chk({31'h0, portb_pullup_disable}, 32'h0);
      wr(ADDR_EDGES, 8'hFF);
      wr(ADDR_PINS, 8'h38);
      rd(ADDR_PINS, 8'h38);
      wr(ADDR_PINS, 8'hC0);
      wr(ADDR_MAIN, 8'h01);
      rd(ADDR_MAIN, 8'h00);
      wr(ADDR_PFLAGS, 8'hFF);
      rd(ADDR_PFLAGS, 8'hCF);
      wr(ADDR_PFLAGS, 8'h00);
      $display("register test done");
      ev(1'b1, 4'h0, 8'h00, 8'h00);
      rd(ADDR_MAIN, 8'h04);
      wr(ADDR_MAIN, 8'h00);
      rd(ADDR_MAIN, 8'h00);
      partner_u.src(1'b0, 4'hF, 8'h00, 8'h00);
      rd(ADDR_MAIN, 8'h02);
      rd(ADDR_PINS, 8'hC7);
      wr(ADDR_MAIN, 8'h00);
      wr(ADDR_PINS, 8'hC0);
      wr(ADDR_EDGES, 8'h87);
      partner_u.src(1'b0, 4'h0, 8'h00, 8'h00);
      rd(ADDR_MAIN, 8'h02);
      rd(ADDR_PINS, 8'hC7);
      wr(ADDR_MAIN, 8'h00);
      wr(ADDR_PINS, 8'hC0);
      wr(ADDR_EDGES, 8'hFF);
      partner_u.src(1'b0, 4'h0, 8'h80, 8'h00);
      wr(ADDR_MAIN, 8'h00);
      rd(ADDR_MAIN, 8'h01);
      partner_u.src(1'b0, 4'h0, 8'h00, 8'h30);
      rd(ADDR_MAIN, 8'h00);
      rd(ADDR_PFLAGS, 8'h30);
      ev(1'b0, 4'h0, 8'h00, 8'hCF);
      rd(ADDR_PFLAGS, 8'hCF);
      wr(ADDR_PFLAGS, 8'h00);
      rd(ADDR_PFLAGS, 8'h00);
      partner_u.src(1'b1, 4'h0, 8'h00, 8'h00);
      wr(ADDR_MAIN, 8'h00);
      partner_u.src(1'b0, 4'h0, 8'h00, 8'h00);
      rd(ADDR_MAIN, 8'h04);
      $display("flag test done");
      wr(ADDR_MAIN, 8'h20);
      ev(1'b1, 4'h0, 8'h00, 8'h00);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b0, VEC_HIGH);
      wr(ADDR_MAIN, 8'hA4);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      wr(ADDR_MAIN, 8'h80);
      partner_u.per(8'h01, 8'h00);
      ev(1'b0, 4'h0, 8'h00, 8'h01);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b0, VEC_HIGH);
      wr(ADDR_MAIN, 8'hC0);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      partner_u.core(1'b1, 1'b0, 1'b1);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b0, VEC_HIGH);
      rd(ADDR_MAIN, 8'h40);
      partner_u.core(1'b0, 1'b1, 1'b1);
      rd(ADDR_MAIN, 8'hC0);
      rq(1'b1, 1'b0, VEC_HIGH);
      $display("compat test done");
      wr(ADDR_MODE, 8'h01);
      rd(ADDR_MODE, 32'h1);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b1, VEC_LOW);
      rd(ADDR_STATUS, 32'h00010018);
      wr(ADDR_MAIN, 8'h80);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b0, VEC_LOW);
      wr(ADDR_MAIN, 8'h40);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b0, VEC_LOW);
      partner_u.per(8'h01, 8'h01);
      wr(ADDR_MAIN, 8'h80);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      partner_u.per(8'h00, 8'h00);
      wr(ADDR_PFLAGS, 8'h00);
      wr(ADDR_EDGES, 8'hFB);
      wr(ADDR_MAIN, 8'hE4);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b1, VEC_LOW);
      wr(ADDR_EDGES, 8'hFF);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      wr(ADDR_MAIN, 8'hC0);
      wr(ADDR_PINS, 8'h09);
      repeat (3) @(posedge hclk);
      rq(1'b0, 1'b1, VEC_LOW);
      wr(ADDR_PINS, 8'h49);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      wr(ADDR_PINS, 8'h09);
      wr(ADDR_MODE, 8'h00);
      repeat (3) @(posedge hclk);
      rq(1'b1, 1'b0, VEC_HIGH);
      rd(ADDR_STATUS, 32'h00020008);
      $display("priority test done");
      close_out();
   end
endmodule : irq_control_and_flag_regs_tb_top
`default_nettype wire
